// ===== bench/dmr_ctl_model.sv
// Controller model that drives the command pins of the block
`timescale 1ns/1ps
`default_nettype none
module dmr_ctl_model #(
  parameter int unsigned MR_GAP = 12
)(
  // Command clock
  input  wire logic        link_clk,
  // Command pins
  output logic             dram_reset_n,
  output logic             cke,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic      [2:0]  ba,
  output logic      [15:0] addr
);
  logic last_mrs;
  // Idle levels from time zero
  initial
  begin
    {dram_reset_n, cke, cs_n, ras_n, cas_n, we_n} = 6'h0f;
    ba = 3'h0;
    addr = 16'h0000;
    last_mrs = 1'b0;
  end
  task automatic do_reset();
    dram_reset_n = 1'b0;
    cke = 1'b0;
    repeat (3) @(negedge link_clk);
    dram_reset_n = 1'b1;
    // Init wait shortened, the block ignores it
    repeat (6) @(negedge link_clk);
    cke = 1'b1;
    repeat (6) @(negedge link_clk);
  endtask
  task automatic issue(input logic [2:0] cmd, input logic [2:0] bank, input logic [15:0] a);
    if (last_mrs)
      repeat (MR_GAP) @(negedge link_clk);
    @(negedge link_clk);
    {cs_n, ras_n, cas_n, we_n} = {1'b0, cmd};
    ba = bank;
    addr = a;
    @(negedge link_clk);
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    // Released bus flips so a stale value never passes
    addr = ~a;
    last_mrs = (cmd == 3'h0);
  endtask
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for mode register zero and burst order
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dmr_pkg::*;
  logic        ref_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        dram_reset_n, cke, cs_n, ras_n, cas_n, we_n;
  logic [2:0]  ba;
  logic [15:0] addr;
  logic [2:0]  beat_col;
  logic        beat_valid, dq_drive_en, write_start, dll_reset_pulse, mode_loaded;
  logic [15:0] mode_register_zero_view;
  int          errors = 0;
  int          checks = 0;
  // Clocks with unrelated periods
  always #50 ref_clk = ~ref_clk;
  always #24 link_clk = ~link_clk;
  dmr_ctl_model dmr_ctl_model_i (.link_clk(link_clk), .dram_reset_n(dram_reset_n), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));
  dmr_core dmr_core_i (.ref_clk(ref_clk), .reset_n(reset_n), .link_clk(link_clk),
    .dram_reset_n(dram_reset_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .beat_col(beat_col), .beat_valid(beat_valid),
    .dq_drive_en(dq_drive_en), .write_start(write_start), .dll_reset_pulse(dll_reset_pulse),
    .mode_register_zero_view(mode_register_zero_view), .mode_loaded(mode_loaded));
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Other bank ignored, then register zero taken
  // register zero load after the other bank
  task automatic mode_write();
    int n;
    check(mode_register_zero_view, 16'h0000);
    dmr_ctl_model_i.issue(3'h0, 3'h2, 16'h0100);
    check(16'(dll_reset_pulse), 16'h0000);
    dmr_ctl_model_i.issue(3'h0, BA_MR0, 16'h010b);
    check(16'(dll_reset_pulse), 16'h0001);
    n = 0;
    while (mode_loaded !== 1'b1 && n < 20)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 20)
    begin
      errors++;
      end_of_test();
    end
    check(mode_register_zero_view, 16'h000b);
  endtask
  // One burst: program mode, send command, judge every slot
  task automatic burst(input logic [1:0] bl, input logic il, input logic wr, input logic [15:0] a);
    logic       chop;
    logic [2:0] i;
    logic [2:0] col;
    int         ws;
    chop = (bl == BL_CHOP4) || (bl == BL_OTF && !a[OTF_BIT]);
    // Start latency 6 after the command, two less for fixed chop
    ws = (bl == BL_CHOP4) ? 4 : 6;
    dmr_ctl_model_i.issue(3'h0, BA_MR0, {12'h000, il, 1'b0, bl});
    dmr_ctl_model_i.issue({2'b10, ~wr}, 3'h0, a);
    for (int n = 1; n <= 10; n++)
    begin
      @(negedge link_clk);
      check(16'(write_start), 16'(wr && n == ws));
      if (n >= 1 && n <= 8)
      begin
        i = 3'(n - 1);
        col = wr ? (chop ? {a[2], i[1:0]} : i) : (il ? a[2:0] ^ i : {a[2] ^ i[2], a[1:0] + i[1:0]});
        if (!chop || !i[2])
          check(16'(beat_col), 16'(col));
        check(16'(beat_valid), 16'(!chop || !i[2]));
        check(16'(dq_drive_en), 16'(!wr && (!chop || !i[2])));
      end
    end
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    dmr_ctl_model_i.do_reset();
    mode_write();
    burst(BL_FIXED8, 1'b0, 1'b0, 16'h0005);
    burst(BL_FIXED8, 1'b1, 1'b0, 16'h0005);
    burst(BL_CHOP4, 1'b1, 1'b0, 16'h0003);
    burst(BL_CHOP4, 1'b0, 1'b0, 16'h0007);
    burst(BL_OTF, 1'b0, 1'b0, 16'h1006);
    burst(BL_OTF, 1'b0, 1'b1, 16'h0005);
    burst(BL_CHOP4, 1'b0, 1'b1, 16'h0006);
    burst(BL_FIXED8, 1'b1, 1'b1, 16'h0003);
    end_of_test();
  end
  // Hang guard
  initial
  begin
    #2000000;
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire

// ===== logic/dmr_core.sv
// Mode register zero capture, burst ordering and write start timing
// How it works
// - Register writes never touch array
// - All low selects register zero
// - Bit three picks burst type
// - Length field, A12 on the fly
// - Eight beat read order rules
// - Chopped reads float last four slots
// - Write order fixed by A2 only
// - Fixed chop write starts two earlier
// - Fly chop write not advanced
`timescale 1ns/1ps
`default_nettype none
module dmr_core
  import dmr_pkg::*;
#(
  parameter int unsigned WR_START_LAT = 6
)(
  // System clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Link command clock and pins
  input  wire logic        link_clk,
  input  wire logic        dram_reset_n,
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic [15:0] addr,
  // Link side burst outputs and DLL reset pulse
  output logic      [2:0]  beat_col,
  output logic             beat_valid,
  output logic             dq_drive_en,
  output logic             write_start,
  output logic             dll_reset_pulse,
  // System side mode view
  output logic      [15:0] mode_register_zero_view,
  output logic             mode_loaded
);
  // ----------------------------------------
  // Link domain command decode
  // ----------------------------------------
  logic link_rst_n;
  logic mrs_cmd;
  logic rdwr_cmd;
  // Pin reset wipes settings even with the link clock stopped
  assign link_rst_n = reset_n & dram_reset_n;
  assign mrs_cmd  = cke & ~cs_n & ~ras_n & ~cas_n & ~we_n & (ba == BA_MR0);
  assign rdwr_cmd = cke & ~cs_n & ras_n & ~cas_n;

  // ----------------------------------------
  // Mode register zero storage
  // ----------------------------------------
  logic [15:0] mode_register_zero, next_mr;
  logic        mr_valid, next_mr_valid;
  logic        mr_toggle, next_mr_toggle;
  logic        next_dll_reset;
  always_comb
  begin
    next_mr         = mode_register_zero;
    next_mr_valid   = mr_valid;
    next_mr_toggle  = mr_toggle;
    next_dll_reset  = 1'b0;
    if (mrs_cmd)
    begin
      next_mr              = addr;
      next_mr[DLL_RST_BIT] = 1'b0;  // DLL reset bit clears itself
      next_mr_valid        = 1'b1;
      next_mr_toggle       = ~mr_toggle;
      next_dll_reset       = addr[DLL_RST_BIT];
    end
  end
  always_ff @(posedge link_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      mode_register_zero <= MR_RESET;
      mr_valid           <= 1'b0;
      mr_toggle          <= 1'b0;
      dll_reset_pulse    <= 1'b0;
    end
    else
    begin
      mode_register_zero <= next_mr;
      mr_valid           <= next_mr_valid;
      mr_toggle          <= next_mr_toggle;
      dll_reset_pulse    <= next_dll_reset;
    end
  end

  // ----------------------------------------
  // Burst sequencer
  // ----------------------------------------
  dmr_state_t  state, next_state;
  logic [2:0]  beat, next_beat;
  logic [2:0]  start, next_start;
  logic        is_wr, next_is_wr;
  logic        chop, next_chop;
  logic        ileave, next_ileave;
  logic [3:0]  wr_cnt, next_wr_cnt;
  logic [2:0]  next_col;
  logic        next_valid;
  logic        next_drive;
  logic        next_wstart;
  logic        cmd_chop;
  logic [1:0]  bl_field;
  assign bl_field = mode_register_zero[BL_LSB +: 2];
  // chop when fixed, or fly with A12 low
  assign cmd_chop = (bl_field == BL_CHOP4) || ((bl_field == BL_OTF) && !addr[OTF_BIT]);

  always_comb
  begin
    next_state  = state;
    next_beat   = beat;
    next_start  = start;
    next_is_wr  = is_wr;
    next_chop   = chop;
    next_ileave = ileave;
    next_wr_cnt = (wr_cnt != 4'h0) ? wr_cnt - 4'h1 : 4'h0;
    next_wstart = (wr_cnt == 4'h1);
    next_col    = 3'h0;
    next_valid  = 1'b0;
    next_drive  = 1'b0;
    case (state)
      DMR_IDLE:
      begin
        if (rdwr_cmd)
        begin
          next_state  = DMR_BURST;
          next_beat   = 3'h0;
          next_start  = addr[2:0];
          next_is_wr  = ~we_n;
          next_chop   = cmd_chop;
          next_ileave = mode_register_zero[BT_BIT];
          if (!we_n)
          begin
            next_wr_cnt = (bl_field == BL_CHOP4) ? 4'(WR_START_LAT) - CHOP_ADVANCE : 4'(WR_START_LAT);
          end
        end
      end
      DMR_BURST:
      begin
        if (is_wr)
        begin
          next_col = chop ? {start[2], beat[1:0]} : beat;
        end
        else if (ileave)
        begin
          next_col = start ^ beat;
        end
        else
        begin
          next_col = {start[2] ^ beat[2], 2'(start[1:0] + beat[1:0])};
        end
        next_valid = !chop || (beat < CHOP_BEATS);
        next_drive = !is_wr && next_valid;
        next_beat  = 3'(beat + 3'h1);
        if (beat == LAST_BEAT)
        begin
          next_state = DMR_IDLE;
        end
      end
      default:
      begin
        next_state = DMR_IDLE;
      end
    endcase
  end
  always_ff @(posedge link_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      state       <= DMR_IDLE;
      beat        <= 3'h0;
      start       <= 3'h0;
      is_wr       <= 1'b0;
      chop        <= 1'b0;
      ileave      <= 1'b0;
      wr_cnt      <= 4'h0;
      beat_col    <= 3'h0;
      beat_valid  <= 1'b0;
      dq_drive_en <= 1'b0;
      write_start <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      beat        <= next_beat;
      start       <= next_start;
      is_wr       <= next_is_wr;
      chop        <= next_chop;
      ileave      <= next_ileave;
      wr_cnt      <= next_wr_cnt;
      beat_col    <= next_col;
      beat_valid  <= next_valid;
      dq_drive_en <= next_drive;
      write_start <= next_wstart;
    end
  end

  // ----------------------------------------
  // Crossing into the system clock domain
  // ----------------------------------------
  // Word is quasi static: register writes are spaced by many link clocks
  logic [2:0]  tog_sync, next_tog_sync;
  logic [1:0]  vld_sync, next_vld_sync;
  logic [15:0] next_view;
  always_comb
  begin
    next_tog_sync = {tog_sync[1:0], mr_toggle};
    next_vld_sync = {vld_sync[0], mr_valid};
    next_view     = (tog_sync[2] != tog_sync[1]) ? mode_register_zero : mode_register_zero_view;
  end
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tog_sync                <= 3'h0;
      vld_sync                <= 2'h0;
      mode_register_zero_view <= MR_RESET;
      mode_loaded             <= 1'b0;
    end
    else
    begin
      tog_sync                <= next_tog_sync;
      vld_sync                <= next_vld_sync;
      mode_register_zero_view <= next_view;
      mode_loaded             <= vld_sync[1];
    end
  end

  // ----------------------------------------
  // Assertions and covers
  // ----------------------------------------
  mr_capture_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    mrs_cmd |=> mode_register_zero == ($past(addr) & ~(16'h0001 << DLL_RST_BIT)))
    else $error("mode register zero not captured");
  dll_selfclear_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    (mrs_cmd && addr[DLL_RST_BIT]) |=> dll_reset_pulse && !mode_register_zero[DLL_RST_BIT] ##1 !dll_reset_pulse)
    else $error("DLL reset pulse wrong");
  ileave_order_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    (state == DMR_BURST && !is_wr && ileave) |=> beat_col == ($past(start) ^ $past(beat)))
    else $error("interleaved order wrong");
  seq_order_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    (state == DMR_BURST && !is_wr && !ileave && beat == 3'h4) |=> beat_col[2] != $past(start[2]))
    else $error("sequential second group wrong");
  chop_float_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    (rdwr_cmd && we_n && state == DMR_IDLE && cmd_chop) |=> ##5 !dq_drive_en [*4])
    else $error("chop read drove late slots");
  wr_order_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    (rdwr_cmd && !we_n && state == DMR_IDLE && !cmd_chop) |=> ##1 beat_col == 3'h0 ##1 beat_col == 3'h1)
    else $error("eight beat write order wrong");
  fixed_chop_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    (rdwr_cmd && !we_n && state == DMR_IDLE && bl_field == BL_CHOP4) |=> ##4 write_start)
    else $error("fixed chop write start not advanced");
  fly_chop_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    (rdwr_cmd && !we_n && state == DMR_IDLE && bl_field == BL_OTF) |=> ##6 write_start)
    else $error("on the fly write start advanced");
  view_cross_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (tog_sync[2] != tog_sync[1]) |=> mode_register_zero_view == $past(mode_register_zero))
    else $error("mode view not updated");
  read_burst_c: cover property (@(posedge link_clk) disable iff (!link_rst_n)
    rdwr_cmd && we_n && state == DMR_IDLE);
  chop_write_c: cover property (@(posedge link_clk) disable iff (!link_rst_n)
    rdwr_cmd && !we_n && state == DMR_IDLE && cmd_chop);
  dll_reset_c: cover property (@(posedge link_clk) disable iff (!link_rst_n)
    mrs_cmd && addr[DLL_RST_BIT]);
endmodule
`default_nettype wire

// ===== pkg/dmr_pkg.sv
// Constants for the mode register zero and burst order logic
package dmr_pkg;
  // ----------------------------------------
  // Mode register zero field layout
  // ----------------------------------------
  localparam int unsigned MR_WIDTH      = 16;
  localparam int unsigned BL_LSB        = 0;
  localparam int unsigned BT_BIT        = 3;
  localparam int unsigned DLL_RST_BIT   = 8;
  localparam int unsigned WR_LSB        = 9;
  localparam int unsigned OTF_BIT       = 12;
  localparam logic [15:0] MR_RESET      = 16'h0000;
  localparam logic [2:0]  BA_MR0        = 3'h0;
  // ----------------------------------------
  // Burst length encodings and beat counts
  // ----------------------------------------
  localparam logic [1:0]  BL_FIXED8     = 2'h0;
  localparam logic [1:0]  BL_OTF        = 2'h1;
  localparam logic [1:0]  BL_CHOP4      = 2'h2;
  localparam logic [2:0]  LAST_BEAT     = 3'h7;
  localparam logic [2:0]  CHOP_BEATS    = 3'h4;
  localparam logic [3:0]  CHOP_ADVANCE  = 4'h2;
  // Burst sequencer states
  typedef enum logic {DMR_IDLE, DMR_BURST} dmr_state_t;
endpackage
